// [rtl/spindle_defs.svh]
// constants for the spindle pulse and thread sync block
// assumes inclusion by bare name from the package and top module
`ifndef SPINDLE_DEFS_SVH
`define SPINDLE_DEFS_SVH
`define OFS_CTRL        8'h00
`define OFS_HALF_PERIOD 8'h04
`define OFS_BASE_DIV    8'h08
`define OFS_DEBOUNCE    8'h0C
`define OFS_PERIOD_CAP  8'h10
`define OFS_STATUS      8'h14
`define OFS_MASK        8'h18
`define OFS_STEP_PUSH   8'h1C
`define OFS_FIFO_LEVEL  8'h20
`define CTRL_RUN_BIT    0
`define CTRL_DIR_BIT    1
`define CTRL_ARM_BIT    2
`define CTRL_TIMING_BIT 3
`define ST_PERIOD_BIT   0
`define ST_INDEX_BIT    1
`define ST_START_BIT    2
`define RST_HALF_PERIOD 32'h0000_0010
`define RST_BASE_DIV    32'h0000_0539
`define RST_DEBOUNCE    32'h0000_0002
`define MIN_HALF_PERIOD 32'h0000_0002
`define CLK_PERIOD_NS   10
`define SENSOR_MIN_NS   60
`define SENSOR_MIN_CYC  ((`SENSOR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [rtl/spindle_pkg.sv]
// types shared by the spindle pulse and thread sync block
// assumes the constants header sits beside it
`include "spindle_defs.svh"
package spindle_pkg;
  typedef struct packed {
    logic [5:0] step;
    logic [5:0] dir;
  } step_entry_t;
  typedef struct packed {
    logic run;
    logic dir;
    logic arm;
    logic use_timing;
  } ctrl_t;
  typedef enum logic [2:0] {
    THR_IDLE  = 3'b001,
    THR_ARMED = 3'b010,
    THR_RUN   = 3'b100
  } thr_state_t;
endpackage

// [rtl/spindle_sync.sv]
// spindle step generator, sensor debounce, period capture and thread start
// assumes synchronous sensor inputs, axi4-lite master on the register side
// Operation
// - spindle step is a 50% square wave set by a register, free running
// - rates to 1MHz normal, ceiling of clock over four
// - sensor pulses longer than about 60 ns are detected
// - each sensor has its own debouncer with configurable lockout
// - armed pass stops fifo fetch while host writes still fill it
// - index pulse while armed restarts fetch within one clock
// - each timing pulse, or index without timing, restarts period counter
// - counter value captured into a register and interrupt raised
// - kernel rate is clock divided by base divisor register
// - step fifo holds twenty six-axis entries, one per kernel tick
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`include "spindle_defs.svh"
module spindle_sync #(
  parameter int FIFO_DEPTH = 20,
  parameter int DB_W       = 16
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     srst_i,
  input  wire logic                     ce_i,
  input  wire logic                     s_axi_awvalid_i,
  output logic                          s_axi_awready_o,
  input  wire logic [7:0]               s_axi_awaddr_i,
  input  wire logic                     s_axi_wvalid_i,
  output logic                          s_axi_wready_o,
  input  wire logic [31:0]              s_axi_wdata_i,
  input  wire logic [3:0]               s_axi_wstrb_i,
  output logic                          s_axi_bvalid_o,
  input  wire logic                     s_axi_bready_i,
  output logic [1:0]                    s_axi_bresp_o,
  input  wire logic                     s_axi_arvalid_i,
  output logic                          s_axi_arready_o,
  input  wire logic [7:0]               s_axi_araddr_i,
  output logic                          s_axi_rvalid_o,
  input  wire logic                     s_axi_rready_i,
  output logic [31:0]                   s_axi_rdata_o,
  output logic [1:0]                    s_axi_rresp_o,
  input  wire logic                     index_i,
  input  wire logic                     timing_i,
  output logic                          spindle_step_o,
  output logic                          spindle_dir_o,
  output spindle_pkg::step_entry_t      axis_o,
  output logic                          irq_o
);
  import spindle_pkg::*;

  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
  localparam int PTR_W = $clog2(FIFO_DEPTH);

  ctrl_t             ctrl;
  logic [31:0]       half_period;
  logic [31:0]       base_div;
  logic [DB_W-1:0]   db_len;
  logic [31:0]       period_cnt;
  logic [31:0]       period_cap;
  logic [2:0]        status;
  logic [2:0]        mask;
  thr_state_t        thr_state;
  logic [31:0]       step_cnt;
  logic [31:0]       kern_cnt;
  logic              kern_tick;
  logic              wr_go;
  logic [7:0]        aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  logic              push;
  logic              pop;
  logic              fifo_full;
  logic              fifo_empty;
  logic              fetch_en;
  logic [LVL_W-1:0]  level;
  logic [PTR_W-1:0]  wr_ptr;
  logic [PTR_W-1:0]  rd_ptr;
  step_entry_t       fifo_mem [FIFO_DEPTH];
  logic [1:0]        db_state;
  logic [1:0]        db_prev;
  logic [DB_W-1:0]   db_cnt [2];
  logic              index_rise;
  logic              timing_rise;
  logic              period_evt;
  logic              start_evt;
  logic [31:0]       next_wdata;

  // write channel capture, address and data may come in either order
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  assign wr_go = aw_held && w_held && !s_axi_bvalid_o;

  // ready flops and write response
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= 2'b00;
    end else if (ce_i) begin
      s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o) && !s_axi_bvalid_o;
      s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o) && !s_axi_bvalid_o;
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (aw_addr > `OFS_STEP_PUSH || aw_addr[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // byte lane merge over the addressed register
  always_comb begin
    next_wdata = 32'h0000_0000;
    unique case (aw_addr)
      `OFS_HALF_PERIOD: next_wdata = half_period;
      `OFS_BASE_DIV:    next_wdata = base_div;
      default:          next_wdata = 32'h0000_0000;
    endcase
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        next_wdata[8*b +: 8] = w_data[8*b +: 8];
      end
    end
  end

  // control registers, each change is one write
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl        <= '0;
      half_period <= `RST_HALF_PERIOD;
      base_div    <= `RST_BASE_DIV;
      db_len      <= DB_W'(`RST_DEBOUNCE);
      mask        <= 3'h0;
    end else if (ce_i && wr_go) begin
      unique case (aw_addr)
        `OFS_CTRL: begin
          if (w_strb[0]) begin
            ctrl.run        <= w_data[`CTRL_RUN_BIT];
            ctrl.dir        <= w_data[`CTRL_DIR_BIT];
            ctrl.arm        <= w_data[`CTRL_ARM_BIT];
            ctrl.use_timing <= w_data[`CTRL_TIMING_BIT];
          end
        end
        `OFS_HALF_PERIOD: half_period <= (next_wdata < `MIN_HALF_PERIOD) ? `MIN_HALF_PERIOD : next_wdata;
        `OFS_BASE_DIV:    base_div <= (next_wdata == 32'h0) ? 32'h0000_0001 : next_wdata;
        `OFS_DEBOUNCE:    db_len <= w_data[DB_W-1:0];
        `OFS_MASK:        mask <= w_data[2:0];
        default: ;
      endcase
    end
  end

  // read channel, one cycle to answer
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= 2'b00;
    end else if (ce_i) begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= 2'b00;
        unique case (s_axi_araddr_i)
          `OFS_CTRL:        s_axi_rdata_o <= {28'h0, ctrl.use_timing, ctrl.arm, ctrl.dir, ctrl.run};
          `OFS_HALF_PERIOD: s_axi_rdata_o <= half_period;
          `OFS_BASE_DIV:    s_axi_rdata_o <= base_div;
          `OFS_DEBOUNCE:    s_axi_rdata_o <= 32'(db_len);
          `OFS_PERIOD_CAP:  s_axi_rdata_o <= period_cap;
          `OFS_STATUS:      s_axi_rdata_o <= {29'h0, status};
          `OFS_MASK:        s_axi_rdata_o <= {29'h0, mask};
          `OFS_STEP_PUSH:   s_axi_rdata_o <= 32'h0000_0000;
          `OFS_FIFO_LEVEL:  s_axi_rdata_o <= {fifo_full, 31'(level)};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= 2'b10;
          end
        endcase
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // spindle square wave, toggles every half period
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      step_cnt       <= 32'h0000_0000;
      spindle_step_o <= 1'b0;
      spindle_dir_o  <= 1'b0;
    end else if (ce_i) begin
      spindle_dir_o <= ctrl.dir;
      if (!ctrl.run && !spindle_step_o) begin // a stop lets the high phase finish
        step_cnt       <= 32'h0000_0000;
        spindle_step_o <= 1'b0;
      end else if (step_cnt + 32'h1 >= half_period) begin
        step_cnt       <= 32'h0000_0000;
        spindle_step_o <= !spindle_step_o;
      end else begin
        step_cnt <= step_cnt + 32'h1;
      end
    end
  end

  // per-input debounce: accept an edge, then lock out changes
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      db_state <= 2'b00;
      db_prev  <= 2'b00;
      db_cnt[0] <= '0;
      db_cnt[1] <= '0;
    end else if (ce_i) begin
      db_prev <= db_state;
      for (int i = 0; i < 2; i++) begin
        if (db_cnt[i] != '0) begin
          db_cnt[i] <= db_cnt[i] - DB_W'(1);
        end else if ((i == 0 ? index_i : timing_i) != db_state[i]) begin
          db_state[i] <= (i == 0) ? index_i : timing_i;
          db_cnt[i]   <= db_len;
        end
      end
    end
  end

  assign index_rise  = db_state[0] && !db_prev[0];
  assign timing_rise = db_state[1] && !db_prev[1];
  assign period_evt  = ctrl.use_timing ? timing_rise : index_rise;
  assign start_evt   = (thr_state == THR_ARMED) && index_rise;

  // period counter and capture
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      period_cnt <= 32'h0000_0000;
      period_cap <= 32'h0000_0000;
    end else if (ce_i) begin
      if (period_evt) begin
        period_cnt <= 32'h0000_0000;
        period_cap <= period_cnt;
      end else if (period_cnt != 32'hFFFF_FFFF) begin
        period_cnt <= period_cnt + 32'h1;
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      status <= 3'h0;
      irq_o  <= 1'b0;
    end else if (ce_i) begin
      for (int i = 0; i < 3; i++) begin
        if ((i == `ST_PERIOD_BIT && period_evt) || (i == `ST_INDEX_BIT && index_rise) ||
            (i == `ST_START_BIT && start_evt)) begin
          status[i] <= 1'b1;
        end else if (wr_go && aw_addr == `OFS_STATUS && w_strb[0] && w_data[i]) begin
          status[i] <= 1'b0;
        end
      end
      irq_o <= |(status & mask);
    end
  end

  // thread pass arming
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      thr_state <= THR_IDLE;
    end else if (ce_i) begin
      unique case (thr_state)
        THR_IDLE:  if (ctrl.arm) thr_state <= THR_ARMED;
        THR_ARMED: begin
          if (!ctrl.arm) thr_state <= THR_IDLE;
          else if (index_rise) thr_state <= THR_RUN;
        end
        THR_RUN:   if (!ctrl.arm) thr_state <= THR_IDLE;
      endcase
    end
  end

  // kernel divider from base divisor
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      kern_cnt <= 32'h0000_0000;
    end else if (ce_i) begin
      kern_cnt <= kern_tick ? 32'h0000_0000 : kern_cnt + 32'h1;
    end
  end

  assign kern_tick = (kern_cnt + 32'h1 >= base_div) || start_evt;
  assign fetch_en  = (thr_state != THR_ARMED);
  assign push      = wr_go && aw_addr == `OFS_STEP_PUSH && !fifo_full;
  assign pop       = kern_tick && fetch_en && !fifo_empty && !(thr_state == THR_ARMED && !start_evt);
  assign fifo_full  = (level == LVL_W'(FIFO_DEPTH));
  assign fifo_empty = (level == '0);

  // step fifo storage and pointers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
      axis_o <= '0;
    end else if (ce_i) begin
      if (push) begin
        fifo_mem[wr_ptr] <= step_entry_t'(w_data[11:0]);
        wr_ptr <= (wr_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
      end
      if (pop || start_evt && !fifo_empty) begin
        axis_o <= fifo_mem[rd_ptr];
        rd_ptr <= (rd_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
      end else if (kern_tick) begin
        axis_o.step <= 6'h00;
      end
      level <= level + LVL_W'(push) - LVL_W'(pop || start_evt && !fifo_empty);
    end
  end
endmodule // spindle_sync

// [testbench/spindle_sync_assertions.sv]
// port checks for the spindle pulse and thread sync block
// assumes one clock domain and a synchronous active high reset
module spindle_sync_assertions (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        spindle_step_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // both write channels taken at one edge
  sequence wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  // read address taken
  sequence rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  a_step_min_high: assert property ($rose(spindle_step_o) |=> spindle_step_o)
    else $error("spindle step high for one cycle only");
  a_step_min_low: assert property ($fell(spindle_step_o) |=> !spindle_step_o)
    else $error("spindle step low for one cycle only");
  a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before taken");
  a_rvalid_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data changed before taken");
  a_write_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  a_read_answer: assert property (rd_take |-> ##[1:2] s_axi_rvalid_o)
    else $error("read data late");
  a_unmapped_err: assert property (rd_take and s_axi_araddr_i > 8'h20 |->
    ##[1:2] (s_axi_rvalid_o && s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0))
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (rd_take and s_axi_araddr_i <= 8'h20 && s_axi_araddr_i[1:0] == 2'b00 |->
    ##[1:2] (s_axi_rvalid_o && s_axi_rresp_o == 2'b00))
    else $error("mapped read refused");
  a_ar_ready_drop: assert property (rd_take |=> !s_axi_arready_o)
    else $error("read address ready kept high");
endmodule // spindle_sync_assertions
bind spindle_sync spindle_sync_assertions u_checks (.*);

// [testbench/spindle_drive_model.sv]
// behavioural spindle drive and rotation sensor pair
// assumes sensor levels change right after the block's clock edge
module spindle_drive_model (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        spindle_step_i,
  input  wire logic        en_i,
  input  wire logic        sel_timing_i,
  input  wire logic [15:0] gap_i,
  input  wire logic [15:0] width_i,
  output logic             index_o,
  output logic             timing_o,
  output int               steps_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  logic        step_q;
  // sensor phase counter, one pulse per gap while enabled
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !en_i) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= (cnt + 16'h0001 == gap_i) ? 16'h0000 : cnt + 16'h0001;
    end
  end
  // pulse of width_i cycles, low between pulses
  always_ff @(posedge clk_sys_i) begin
    index_o  <= en_i && !sel_timing_i && cnt < width_i;
    timing_o <= en_i && sel_timing_i && cnt < width_i;
  end
  // drive counts the step rises it would turn on
  always_ff @(posedge clk_sys_i) begin
    step_q <= spindle_step_i;
    if (srst_i) begin
      steps_o <= 0;
    end else if (spindle_step_i && !step_q) begin
      steps_o <= steps_o + 1;
    end
  end
endmodule // spindle_drive_model

// [testbench/spindle_sync_bench.sv]
// self-checking bench for the spindle pulse and thread sync block
// assumes design, drive model and checker compiled before it
`include "spindle_defs.svh"
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module spindle_sync_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spindle_pkg::*;
  logic        clk_sys_i, srst_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, step, dir, irq, index, timing, m_en, m_sel, ce, held;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] lfsr, gap, width;
  step_entry_t axis, first;
  int          errors, tests_run, steps, n, hi, lo, kdiv;
  int          cycles = 0;
  localparam int PLAN_REF = 64; // software planning reference for divisor scaling
  spindle_sync dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .index_i(index), .timing_i(timing), .spindle_step_o(step), .spindle_dir_o(dir),
    .axis_o(axis), .irq_o(irq));
  spindle_drive_model drive (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .spindle_step_i(step),
    .en_i(m_en), .sel_timing_i(m_sel), .gap_i(gap), .width_i(width),
    .index_o(index), .timing_o(timing), .steps_o(steps));
  // free running clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // cuts a hang short
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // write one word, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", 2'b00, bresp)
  endtask
  // read one word into rd and rs
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask
  // edges during which the step output holds one level
  task automatic span(input logic lvl, output int c);
    c = 0;
    while (step === lvl && c < 1000) begin
      @(posedge clk_sys_i);
      c++;
    end
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, m_en, m_sel} = '0;
    {awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    kdiv = `RST_BASE_DIV;
    gap = 16'h0032;
    width = 16'h0006;
    lfsr = 16'h0028;
    errors = 0;
    tests_run = 0;
    srst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd_reg(`OFS_PERIOD_CAP);
    `CHK("period_cap", 32'h0, rd)
    `CHK("step_idle", 1'b0, step)
    rd_reg(`OFS_BASE_DIV);
    `CHK("base_div", `RST_BASE_DIV, rd)
    rd_reg(8'h40);
    `CHK("unmapped", 2'b10, rs)
    $display("test reset done");
    // square wave at the smallest and random half periods
    for (int i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      n = (i == 0) ? 2 : 3 + lfsr[3:0];
      wr(`OFS_HALF_PERIOD, n);
      wr(`OFS_CTRL, 32'h3);
      span(1'b0, hi);
      span(1'b1, hi);
      span(1'b0, lo);
      `CHK("high_time", n, hi)
      `CHK("low_time", n, lo)
      `CHK("dir", 1'b1, dir)
      ce <= 1'b0;
      @(posedge clk_sys_i);
      held = step;
      repeat (n + 2) @(posedge clk_sys_i);
      `CHK("frozen", held, step)
      ce <= 1'b1;
      wr(`OFS_CTRL, 32'h0);
      repeat (2 * n + 4) @(posedge clk_sys_i);
      `CHK("stopped", 1'b0, step)
    end
    `CHK("drive_steps", 1'b1, steps > 0)
    $display("test spindle done");
    // period capture from index, then from timing sensor
    wr(`OFS_MASK, 32'h1);
    wr(`OFS_DEBOUNCE, 32'h4);
    rd_reg(`OFS_DEBOUNCE);
    `CHK("debounce", 32'h4, rd)
    for (int i = 0; i < 2; i++) begin
      lfsr = next_rand(lfsr);
      gap <= 16'd30 + lfsr[5:0];
      m_sel <= i[0];
      wr(`OFS_CTRL, i ? 32'h8 : 32'h0);
      m_en <= 1'b1;
      repeat (376) @(posedge clk_sys_i);
      rd_reg(`OFS_PERIOD_CAP);
      `CHK("period_cap", {16'h0, gap} - 32'h1, rd)
      `CHK("irq", 1'b1, irq)
      kdiv = (kdiv * rd) / PLAN_REF;
      wr(`OFS_BASE_DIV, kdiv);
      rd_reg(`OFS_BASE_DIV);
      `CHK("base_div_scaled", kdiv, rd)
      m_en <= 1'b0;
      wr(`OFS_STATUS, 32'h7);
      repeat (3) @(posedge clk_sys_i);
      `CHK("irq_clear", 1'b0, irq)
    end
    wr(`OFS_MASK, 32'h0);
    m_en <= 1'b1;
    repeat (200) @(posedge clk_sys_i);
    `CHK("irq_masked", 1'b0, irq)
    rd_reg(`OFS_STATUS);
    `CHK("status_period", 1'b1, rd[0])
    m_en <= 1'b0;
    wr(`OFS_STATUS, 32'h7);
    $display("test period done");
    // armed pass: fifo fills, index starts it
    wr(`OFS_BASE_DIV, 32'h4);
    wr(`OFS_CTRL, 32'h4);
    for (int i = 0; i < 22; i++) begin
      lfsr = next_rand(lfsr);
      if (i == 0) first = {lfsr[11:6] | 6'h01, lfsr[5:0]};
      wr(`OFS_STEP_PUSH, {20'h0, lfsr[11:6] | 6'h01, lfsr[5:0]});
    end
    rd_reg(`OFS_FIFO_LEVEL);
    `CHK("fifo_full", 32'h8000_0014, rd)
    `CHK("held_axis", 12'h000, axis)
    m_sel <= 1'b0;
    gap <= 16'd400;
    m_en <= 1'b1;
    n = 0;
    while (axis.step === 6'h00 && n < 50) begin
      @(posedge clk_sys_i);
      n++;
    end
    `CHK("first_entry", first, axis)
    `CHK("start_delay", 1'b1, n <= 6)
    repeat (39) @(posedge clk_sys_i);
    rd_reg(`OFS_FIFO_LEVEL);
    `CHK("fifo_paced", 32'h9, rd)
    repeat (200) @(posedge clk_sys_i);
    rd_reg(`OFS_FIFO_LEVEL);
    `CHK("fifo_drained", 32'h0, rd)
    rd_reg(`OFS_STATUS);
    `CHK("status_start", 2'b11, rd[2:1])
    m_en <= 1'b0;
    $display("test thread done");
    report_and_stop();
  end
endmodule // spindle_sync_bench
